// [hdl/mssr_pkg.sv]
// mssr_pkg: constants shared by the memory select and flash reset block
// assumes a single 40 MHz core clock; nothing here is clocked
package mssr_pkg;

  // core clock rate and the flash recovery time
  localparam int unsigned CLK_MHZ         = 40;       // core_clk_i rate in MHz
  localparam int unsigned RECOVERY_US     = 25;       // flash return-to-read time, us
  localparam int unsigned RECOVERY_CYCLES = RECOVERY_US * CLK_MHZ;
  localparam int unsigned RCNT_W          = $clog2(RECOVERY_CYCLES);

  // register offsets inside the register block space
  localparam logic [7:0] OFF_PAGE      = 8'he0;   // memory_page
  localparam logic [7:0] OFF_SPACE_MAP = 8'he2;   // space_mapping
  localparam logic [7:0] OFF_ID0       = 8'hf0;   // memory_config_id0
  localparam logic [7:0] OFF_ID1       = 8'hf1;   // memory_config_id1

  // reset values and the mapping store mask
  localparam logic [7:0] PAGE_RESET      = 8'h00;
  localparam logic [7:0] SPACE_MAP_INIT  = 8'h0c;   // default start-up mapping
  localparam logic [7:0] SPACE_MAP_MASK  = 8'h9f;   // bits 6 and 5 are not stored

  // space_mapping field positions
  localparam int unsigned VM_SRAM_FETCH = 0;
  localparam int unsigned VM_BOOT_FETCH = 1;
  localparam int unsigned VM_MAIN_FETCH = 2;
  localparam int unsigned VM_BOOT_READ  = 3;
  localparam int unsigned VM_MAIN_READ  = 4;
  localparam int unsigned VM_PORT_IO    = 7;

  // flash reset instruction data byte
  localparam logic [7:0] RESET_CMD = 8'hf0;

  // flash engine activity codes
  localparam logic [1:0] OP_NONE    = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_BULK    = 2'h2;
  localparam logic [1:0] OP_SECTOR  = 2'h3;

  // pin synchroniser bundle: {addr,data,rd_n,wr_n,program_fetch_strobe_n,io,sram,main,boot,rst_n}
  localparam int unsigned    SYNC_W    = 42;
  localparam logic [41:0]    SYNC_IDLE = 42'h00000038001;   // strobes and reset idle high

  // flash mode tracking
  typedef enum logic [1:0] {FL_READ, FL_BUSY, FL_RECOVER} mssr_flash_e;

endpackage : mssr_pkg

// [hdl/mssr_sel_if.sv]
// mssr_sel_if: decoder selects, strobes and mapping in, memory enables out
// assumes every signal is already in the core clock domain
`timescale 1ns/100ps
interface mssr_sel_if;
  logic       sram_sel;    // sram_select
  logic       io_sel;      // register_block_select
  logic [3:0] boot_sel;    // boot_sector_select
  logic [7:0] main_sel;    // main_sector_select
  logic       fetch;       // program_fetch_strobe active
  logic       read;        // read strobe active
  logic       write;       // write strobe active
  logic [7:0] space_map;   // space_mapping_register
  logic       en_sram;     // resolved sram enable
  logic       en_io;       // resolved register block enable
  logic [3:0] en_boot;     // resolved boot sector enables
  logic [7:0] en_main;     // resolved main sector enables

  modport decode (input sram_sel, io_sel, boot_sel, main_sel, fetch, read, write, space_map,
                  output en_sram, en_io, en_boot, en_main);
  modport owner  (output sram_sel, io_sel, boot_sel, main_sel, fetch, read, write, space_map,
                  input en_sram, en_io, en_boot, en_main);
endinterface : mssr_sel_if

// [hdl/mssr_select.sv]
// mssr_select: priority resolution of overlapping memory selects
// assumes selects and strobes arrive synchronised; purely combinational
`timescale 1ns/100ps
module mssr_select
  import mssr_pkg::*;
(
  mssr_sel_if.decode sel
);

  logic sram_ok;   // strobe may reach sram
  logic boot_ok;   // strobe may reach boot flash
  logic main_ok;   // strobe may reach main flash

  // per-memory strobe gating by the space mapping bits
  always_comb begin
    sram_ok = sel.write | sel.read | (sel.fetch & sel.space_map[VM_SRAM_FETCH]);
    boot_ok = sel.write | (sel.read & sel.space_map[VM_BOOT_READ])
            | (sel.fetch & sel.space_map[VM_BOOT_FETCH]);
    main_ok = sel.write | (sel.read & sel.space_map[VM_MAIN_READ])
            | (sel.fetch & sel.space_map[VM_MAIN_FETCH]);
  end

  // sram or registers first, then boot flash, then main flash
  always_comb begin
    sel.en_sram = 1'b0;
    sel.en_io   = 1'b0;
    sel.en_boot = 4'h0;
    sel.en_main = 8'h0;
    if (sel.sram_sel) begin
      sel.en_sram = sram_ok;
    end else if (sel.io_sel) begin
      sel.en_io = sel.read | sel.write;
    end else if (|sel.boot_sel) begin
      sel.en_boot = boot_ok ? sel.boot_sel : 4'h0;
    end else begin
      sel.en_main = main_ok ? sel.main_sel : 8'h0;
    end
  end

endmodule : mssr_select

// [hdl/mssr_top.sv]
// mssr_top: memory select, mapping registers and flash reset handling
// assumes asynchronous mcu pins and decoder selects; flash engine on core_clk_i
// What this block does
// - reset command is one write, unlock optional
// - reset returns read mode, 25 us on error
// - reset ignored during program or bulk erase
// - reset aborts sector erase, 25 us recovery
// - reset pin aborts, read mode within 25 us
// - sram enabled only while its select high
// - boot sector wins over main sector
// - sram or registers win over flash
// - mapping bits gate strobe per memory
// - bit 7 port io, bits 6-5 unused
// - mapping loads initial value, rewritable live
// - eight bit page register at e0h
// - page bits feed the address decoder
// - id0 holds sram and flash size codes
// - id1 holds zeros, boot type, boot size
`timescale 1ns/100ps
module mssr_top
  import mssr_pkg::*;
#(
  parameter logic [7:0] SPACE_MAP_START = SPACE_MAP_INIT,  // start-up mapping value
  parameter logic [3:0] SRAM_SIZE_CODE  = 4'h3,            // sram size code
  parameter logic [3:0] MAIN_SIZE_CODE  = 4'h5,            // main flash size code
  parameter logic [1:0] BOOT_TYPE_CODE  = 2'h0,            // boot block type
  parameter logic [3:0] BOOT_SIZE_CODE  = 4'h2             // boot block size code
) (
  input  wire logic        core_clk_i,               // core clock
  input  wire logic        reset_i,                  // synchronous reset
  input  wire logic [15:0] addr_i,                   // mcu address pins
  input  wire logic [7:0]  data_i,                   // mcu data pins, low byte
  input  wire logic        rd_n_i,                   // mcu read strobe
  input  wire logic        wr_n_i,                   // mcu write strobe
  input  wire logic        program_fetch_strobe_n_i, // mcu code fetch strobe
  input  wire logic        register_block_select_i,  // decoder register select
  input  wire logic        sram_select_i,            // decoder sram select
  input  wire logic [7:0]  main_sector_select_i,     // decoder main sector selects
  input  wire logic [3:0]  boot_sector_select_i,     // decoder boot sector selects
  input  wire logic        reset_pin_n_i,            // external reset pin
  input  wire logic [1:0]  flash_op_i,               // flash engine activity
  input  wire logic        error_status_bit_i,       // flash engine error flag
  output logic [7:0]       data_o,                   // register read data
  output logic             data_oe_o,                // data pins driven
  output logic             sram_enable_o,            // sram enable
  output logic [3:0]       boot_enable_o,            // boot sector enables
  output logic [7:0]       main_enable_o,            // main sector enables
  output logic [7:0]       page_bits_o,              // page register to decoder
  output logic             port_io_enable_o,         // port io mode
  output logic             flash_read_mode_o,        // flash is in read mode
  output logic             flash_abort_o             // abort pulse to flash engine
);

  mssr_sel_if sel ();                        // select resolver carrier

  logic [SYNC_W-1:0] sync_a;                 // first synchroniser stage
  logic [SYNC_W-1:0] sync_b;                 // second synchroniser stage
  logic [15:0]       s_addr;                 // synchronised address
  logic [7:0]        s_data;                 // synchronised data
  logic              s_rst_n;                // synchronised reset pin
  logic              wr_prev;                // write strobe last cycle
  logic              rst_prev_n;             // reset pin last cycle
  logic              wr_start;               // write strobe just asserted
  logic              pin_pulse;              // reset pin just asserted
  logic              rst_cmd;                // flash reset instruction seen
  logic [7:0]        memory_page;            // page register
  logic [7:0]        space_mapping;          // space mapping register
  logic [7:0]        memory_config_id0;      // id register 0
  logic [7:0]        memory_config_id1;      // id register 1
  logic [7:0]        next_data;              // read mux
  mssr_flash_e       state;                  // flash mode
  logic [RCNT_W-1:0] count;                  // recovery countdown
  logic              op_locked;              // program or bulk erase running

  // two flip-flops on every pin before use
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
    end else begin
      sync_a <= {addr_i, data_i, rd_n_i, wr_n_i, program_fetch_strobe_n_i,
                 register_block_select_i, sram_select_i, main_sector_select_i,
                 boot_sector_select_i, reset_pin_n_i};
      sync_b <= sync_a;
    end
  end

  // unpack the synchronised bundle into the resolver
  assign s_addr        = sync_b[41:26];
  assign s_data        = sync_b[25:18];
  assign sel.read      = ~sync_b[17];
  assign sel.write     = ~sync_b[16];
  assign sel.fetch     = ~sync_b[15];
  assign sel.io_sel    = sync_b[14];
  assign sel.sram_sel  = sync_b[13];
  assign sel.main_sel  = sync_b[12:5];
  assign sel.boot_sel  = sync_b[4:1];
  assign s_rst_n       = sync_b[0];
  assign sel.space_map = space_mapping;

  mssr_select u_select (
    .sel (sel)
  );

  // edge detection of write strobe and reset pin
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_prev    <= 1'b0;
      rst_prev_n <= 1'b1;
    end else begin
      wr_prev    <= sel.write;
      rst_prev_n <= s_rst_n;
    end
  end

  assign wr_start  = sel.write & ~wr_prev;
  assign pin_pulse = ~s_rst_n & rst_prev_n;
  // one write of the reset byte to flash; unlock writes before it are harmless
  assign rst_cmd   = wr_start & ((|sel.en_boot) | (|sel.en_main)) & (s_data == RESET_CMD);
  assign op_locked = (flash_op_i == OP_PROGRAM) | (flash_op_i == OP_BULK);

  // writable registers in the register block
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      memory_page   <= PAGE_RESET;
      space_mapping <= SPACE_MAP_START & SPACE_MAP_MASK;
    end else if (wr_start && sel.en_io) begin
      if (s_addr[7:0] == OFF_PAGE) begin
        memory_page <= s_data;
      end
      if (s_addr[7:0] == OFF_SPACE_MAP) begin
        space_mapping <= s_data & SPACE_MAP_MASK;
      end
    end
  end

  // read-only configuration registers
  assign memory_config_id0 = {SRAM_SIZE_CODE, MAIN_SIZE_CODE};
  assign memory_config_id1 = {2'h0, BOOT_TYPE_CODE, BOOT_SIZE_CODE};

  // register read mux, unmapped offsets read zero
  always_comb begin
    case (s_addr[7:0])
      OFF_PAGE:      next_data = memory_page;
      OFF_SPACE_MAP: next_data = space_mapping;
      OFF_ID0:       next_data = memory_config_id0;
      OFF_ID1:       next_data = memory_config_id1;
      default:       next_data = 8'h00;
    endcase
  end

  // registered outputs toward bus and memories
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      data_o           <= 8'h00;
      data_oe_o        <= 1'b0;
      sram_enable_o    <= 1'b0;
      boot_enable_o    <= 4'h0;
      main_enable_o    <= 8'h0;
      page_bits_o      <= PAGE_RESET;
      port_io_enable_o <= 1'b0;
    end else begin
      data_o           <= next_data;
      data_oe_o        <= sel.en_io & sel.read;
      sram_enable_o    <= sel.en_sram;
      boot_enable_o    <= sel.en_boot;
      main_enable_o    <= sel.en_main;
      page_bits_o      <= memory_page;
      port_io_enable_o <= space_mapping[VM_PORT_IO];
    end
  end

  // flash mode: read, busy, or timed recovery after an abort
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state         <= FL_READ;
      count         <= '0;
      flash_abort_o <= 1'b0;
    end else begin
      flash_abort_o <= 1'b0;
      if (pin_pulse) begin
        flash_abort_o <= 1'b1;
        if (state == FL_BUSY || flash_op_i != OP_NONE) begin
          state <= FL_RECOVER;
          count <= RCNT_W'(RECOVERY_CYCLES - 1);
        end else begin
          state <= FL_READ;
        end
      end else if (rst_cmd && !op_locked) begin
        if (flash_op_i == OP_SECTOR || error_status_bit_i) begin
          flash_abort_o <= 1'b1;
          state         <= FL_RECOVER;
          count         <= RCNT_W'(RECOVERY_CYCLES - 1);
        end else begin
          state <= FL_READ;
        end
      end else begin
        case (state)
          FL_READ:    if (flash_op_i != OP_NONE) state <= FL_BUSY;
          FL_BUSY:    if (flash_op_i == OP_NONE) state <= FL_READ;
          FL_RECOVER: begin
            if (count == '0) begin
              state <= FL_READ;
            end else begin
              count <= count - 1'b1;
            end
          end
          default:    state <= FL_READ;
        endcase
      end
    end
  end

  // read mode flag from its own flip-flop
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flash_read_mode_o <= 1'b1;
    end else begin
      flash_read_mode_o <= (state == FL_READ);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  chk_locked_reset_ignored: assert property (
    rst_cmd && op_locked && !pin_pulse |=> !flash_abort_o
      && (state != FL_RECOVER || $past(state) == FL_RECOVER))
    else $error("reset command acted during program or bulk erase");

  chk_sector_abort_recover: assert property (
    rst_cmd && flash_op_i == OP_SECTOR && !pin_pulse |=> flash_abort_o ##0 state == FL_RECOVER
      ##0 count == RCNT_W'(RECOVERY_CYCLES - 1))
    else $error("sector erase not aborted with full recovery");

  chk_plain_reset_read: assert property (
    rst_cmd && flash_op_i == OP_NONE && !error_status_bit_i && !pin_pulse
      |=> state == FL_READ ##1 flash_read_mode_o)
    else $error("plain reset command did not give read mode");

  chk_recovery_end: assert property (
    state == FL_RECOVER && count == '0 && !pin_pulse && !rst_cmd |=> state == FL_READ)
    else $error("recovery did not end at zero count");

  chk_pin_abort: assert property (
    pin_pulse |=> flash_abort_o ##1 !flash_abort_o)
    else $error("reset pin did not give a one-cycle abort");

  chk_single_enable: assert property (
    $onehot0(sel.main_sel) && $onehot0(sel.boot_sel)
      |=> $onehot0({sram_enable_o, boot_enable_o, main_enable_o, data_oe_o}))
    else $error("more than one memory enabled");

  chk_boot_over_main: assert property (
    |sel.boot_sel && !sel.sram_sel && !sel.io_sel |-> sel.en_main == 8'h0)
    else $error("main flash enabled under a boot select");

  chk_sram_over_flash: assert property (
    sel.sram_sel && (sel.read || sel.write) |-> sel.en_sram && sel.en_boot == 4'h0
      && sel.en_main == 8'h0)
    else $error("sram lost priority to flash");

  chk_sram_needs_select: assert property (
    !sel.sram_sel |=> !sram_enable_o)
    else $error("sram enabled without its select");

  chk_fetch_gate: assert property (
    sel.fetch && !sel.read && !sel.write && !space_mapping[VM_MAIN_FETCH]
      |-> sel.en_main == 8'h0)
    else $error("fetch reached main flash while gated");

  chk_page_write: assert property (
    wr_start && sel.en_io && s_addr[7:0] == OFF_PAGE |=> memory_page == $past(s_data)
      ##1 page_bits_o == $past(s_data, 2))
    else $error("page register write not taken");

endmodule : mssr_top

// [tb/mssr_mcu_model.sv]
// mcu bus model: address, data, strobes, decoder selects and reset pin
// assumes callers wait on core_clk_i; pins change only after rising edges
`timescale 1ns/100ps
module mssr_mcu_model
  import mssr_pkg::*;
(
  input  wire logic  core_clk_i,   // core clock
  output logic [15:0] addr_o,      // address pins
  output logic [7:0]  data_o,      // data low byte
  output logic        rd_n_o,      // read strobe
  output logic        wr_n_o,      // write strobe
  output logic        fetch_n_o,   // code fetch strobe
  output logic        io_sel_o,    // register block select
  output logic        sram_sel_o,  // sram select
  output logic [7:0]  main_sel_o,  // main sector selects
  output logic [3:0]  boot_sel_o,  // boot sector selects
  output logic        pin_n_o      // reset pin
);
  // idle bus at time zero
  initial begin
    {addr_o, data_o, io_sel_o, sram_sel_o, main_sel_o, boot_sel_o} = '0;
    {rd_n_o, wr_n_o, fetch_n_o, pin_n_o} = 4'hf;
  end
  // one cycle: kind 0 read, 1 write, 2 fetch; held past sync and decode
  task automatic drive(input int kind, input logic [15:0] a, input logic [7:0] d,
                       input logic io, input logic sram, input logic [7:0] m,
                       input logic [3:0] b);
    @(posedge core_clk_i);
    addr_o <= a;
    data_o <= d;
    io_sel_o <= io;
    sram_sel_o <= sram;
    main_sel_o <= m;
    boot_sel_o <= b;
    rd_n_o <= (kind != 0);
    wr_n_o <= (kind != 1);
    fetch_n_o <= (kind != 2);
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask : drive
  // release strobes and selects; data shows no stale value
  task automatic idle();
    @(posedge core_clk_i);
    {rd_n_o, wr_n_o, fetch_n_o} <= 3'h7;
    {io_sel_o, sram_sel_o, main_sel_o, boot_sel_o} <= '0;
    data_o <= ~data_o;
    repeat (3) @(posedge core_clk_i);
  endtask : idle
  // reset pin pulse as long as the flash recovery
  task automatic pin_pulse();
    @(posedge core_clk_i);
    pin_n_o <= 1'b0;
    repeat (RECOVERY_CYCLES) @(posedge core_clk_i);
    pin_n_o <= 1'b1;
  endtask : pin_pulse
endmodule : mssr_mcu_model

// [tb/mssr_top_tb.sv]
// bench for mssr_top: mcu model on the pins, flash engine driven here
// assumes a 40 MHz core clock and the package recovery count
`timescale 1ns/100ps
module mssr_top_tb;
  import mssr_pkg::*;
  localparam logic [7:0] VM_START = 8'h8c;  // start mapping, port io on
  logic        core_clk_i = 1'b0;          // core clock
  logic        reset_i = 1'b1;             // synchronous reset
  logic [1:0]  flash_op_i = OP_NONE;       // flash engine activity
  logic        error_status_bit_i = 1'b0;  // flash error flag
  wire logic [15:0] addr_i;                // address pins
  wire logic [7:0]  data_i, main_sector_select_i;
  wire logic [3:0]  boot_sector_select_i;
  wire logic rd_n_i, wr_n_i, program_fetch_strobe_n_i;
  wire logic register_block_select_i, sram_select_i, reset_pin_n_i;
  logic [7:0] data_o, page_bits_o, main_enable_o;  // design outputs
  logic [3:0] boot_enable_o;
  logic data_oe_o, sram_enable_o, port_io_enable_o, flash_read_mode_o, flash_abort_o;
  int n_mismatch = 0;                 // mismatches seen
  int checks_done = 0;                // comparisons made
  logic [31:0] rnd = 32'h6b6cf4fa;    // random state
  // 25 ns clock
  always #12.5 core_clk_i = ~core_clk_i;
  mssr_top #(.SPACE_MAP_START(VM_START), .SRAM_SIZE_CODE(4'h2), .MAIN_SIZE_CODE(4'h4),
             .BOOT_TYPE_CODE(2'h1), .BOOT_SIZE_CODE(4'h3)) mssr_top_i (
    .core_clk_i, .reset_i, .addr_i, .data_i, .rd_n_i, .wr_n_i, .program_fetch_strobe_n_i,
    .register_block_select_i, .sram_select_i, .main_sector_select_i, .boot_sector_select_i,
    .reset_pin_n_i, .flash_op_i, .error_status_bit_i, .data_o, .data_oe_o, .sram_enable_o,
    .boot_enable_o, .main_enable_o, .page_bits_o, .port_io_enable_o, .flash_read_mode_o,
    .flash_abort_o);
  mssr_mcu_model mcu (.core_clk_i, .addr_o(addr_i), .data_o(data_i), .rd_n_o(rd_n_i),
    .wr_n_o(wr_n_i), .fetch_n_o(program_fetch_strobe_n_i), .io_sel_o(register_block_select_i),
    .sram_sel_o(sram_select_i), .main_sel_o(main_sector_select_i),
    .boot_sel_o(boot_sector_select_i), .pin_n_o(reset_pin_n_i));
  // next random value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // register read through the register block select
  task automatic reg_rd(input logic [7:0] off, input logic [7:0] exp);
    mcu.drive(0, {8'h00, off}, 8'h5a, 1'b1, 1'b0, 8'h00, 4'h0);
    check(data_o, exp, "register read");
    check({7'h0, data_oe_o}, 8'h01, "read drive");
    mcu.idle();
  endtask : reg_rd
  // register write, sram select optional
  task automatic reg_wr(input logic [7:0] off, input logic [7:0] d, input logic sram);
    mcu.drive(1, {8'h00, off}, d, 1'b1, sram, 8'h00, 4'h0);
    mcu.idle();
  endtask : reg_wr
  // one select pattern against the priority and mapping model
  task automatic sel_case(input logic [7:0] vm, input logic [31:0] r);
    logic rd, fe, es, gb, gm;
    logic [3:0] b, eb;
    logic [7:0] m, em;
    rd = ~r[0];
    fe = r[0];
    m = r[3] ? 8'h01 << r[6:4] : 8'h00;
    b = r[7] ? 4'h1 << r[9:8] : 4'h0;
    gb = (rd & vm[VM_BOOT_READ]) | (fe & vm[VM_BOOT_FETCH]);
    gm = (rd & vm[VM_MAIN_READ]) | (fe & vm[VM_MAIN_FETCH]);
    es = r[1] & (rd | (fe & vm[VM_SRAM_FETCH]));
    eb = (r[1] | r[2]) ? 4'h0 : b & {4{gb}};
    em = (r[1] | r[2] | (b != 4'h0)) ? 8'h00 : m & {8{gm}};
    mcu.drive(r[0] ? 2 : 0, r[31:16], 8'h00, r[2], r[1], m, b);
    check({7'h0, sram_enable_o}, {7'h0, es}, "sram enable");
    check({4'h0, boot_enable_o}, {4'h0, eb}, "boot enable");
    check(main_enable_o, em, "main enable");
    mcu.idle();
  endtask : sel_case
  // fc = {op, error, pin, mode}; mode 0 ignored, 1 immediate, 2 recovery, 3 within
  task automatic flash_case(input logic [5:0] fc);
    int w;
    @(posedge core_clk_i);
    flash_op_i <= fc[5:4];
    error_status_bit_i <= fc[3];
    repeat (3) @(posedge core_clk_i);
    fork
      if (fc[2]) mcu.pin_pulse(); else mcu.drive(1, 16'h0aaa, RESET_CMD, 1'b0, 1'b0, 8'h01, 4'h0);
    join_none
    for (w = 0; w < 20 && flash_abort_o !== 1'b1; w++) @(posedge core_clk_i);
    flash_op_i <= OP_NONE;
    error_status_bit_i <= 1'b0;
    // a plain command returns to read mode with no abort; pin or recovery always aborts
    check({7'h0, w < 20}, {7'h0, fc[2] | fc[1]}, "abort pulse");
    if (w == 20 && (fc[2] | fc[1])) end_of_test();
    repeat (fc[1:0] == 2'd1 ? 4 : 990) @(posedge core_clk_i);
    #1;
    if (fc[1] ^ fc[0]) check({7'h0, flash_read_mode_o}, {7'h0, fc[0]}, "early mode");
    repeat (fc[1:0] == 2'd1 ? 1011 : 15) @(posedge core_clk_i);
    #1;
    check({7'h0, flash_read_mode_o}, 8'h01, "read mode");
    if (!fc[2]) mcu.idle();
  endtask : flash_case
  // counts and verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    logic [7:0] vm;
    logic [5:0] fcase [8];
    fcase = '{6'h10, 6'h28, 6'h32, 6'h0a, 6'h01, 6'h36, 6'h05, 6'h17};
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    check(page_bits_o, PAGE_RESET, "page at reset");
    check({7'h0, port_io_enable_o}, {7'h0, VM_START[VM_PORT_IO]}, "port io at reset");
    check({7'h0, flash_read_mode_o}, 8'h01, "read mode at reset");
    reg_rd(OFF_PAGE, PAGE_RESET);
    reg_rd(OFF_SPACE_MAP, VM_START);
    reg_wr(OFF_ID0, 8'hff, 1'b0);
    reg_rd(OFF_ID0, 8'h24);
    reg_rd(OFF_ID1, 8'h13);
    // reset command after the id reads, before normal flash reads
    mcu.drive(1, 16'h0aaa, RESET_CMD, 1'b0, 1'b0, 8'h01, 4'h0);
    mcu.idle();
    check({7'h0, flash_read_mode_o}, 8'h01, "read mode after id");
    reg_rd(8'he4, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      reg_wr(OFF_PAGE, rnd[7:0], 1'b0);
      reg_rd(OFF_PAGE, rnd[7:0]);
      check(page_bits_o, rnd[7:0], "page to decoder");
    end
    reg_wr(OFF_PAGE, ~rnd[7:0], 1'b1);
    reg_rd(OFF_PAGE, rnd[7:0]);
    reg_wr(OFF_SPACE_MAP, 8'h7f, 1'b0);
    reg_rd(OFF_SPACE_MAP, 8'h1f);
    check({7'h0, port_io_enable_o}, 8'h00, "port io off");
    reg_wr(OFF_SPACE_MAP, 8'he0, 1'b0);
    reg_rd(OFF_SPACE_MAP, 8'h80);
    check({7'h0, port_io_enable_o}, 8'h01, "port io on");
    $display("test registers done");
    for (int r = 0; r < 6; r++) begin
      rnd = lfsr(rnd);
      vm = (r == 0) ? 8'h0c : (r == 1) ? 8'h14 : rnd[7:0];
      reg_wr(OFF_SPACE_MAP, vm, 1'b0);
      for (int k = 0; k < 8; k++) begin
        rnd = lfsr(rnd);
        sel_case(vm, rnd);
      end
    end
    $display("test selects done");
    mcu.drive(1, 16'h0aaa, 8'haa, 1'b0, 1'b0, 8'h01, 4'h0);
    mcu.idle();
    mcu.drive(1, 16'h0554, 8'h55, 1'b0, 1'b0, 8'h01, 4'h0);
    mcu.idle();
    for (int i = 0; i < 8; i++) flash_case(fcase[i]);
    $display("test flash_reset done");
    end_of_test();
  end
endmodule : mssr_top_tb
